// ==== clk_div_if.sv ====
// Carrier between the shift engine and the serial clock divider
`timescale 1ns/10ps
interface clk_div_if;
   logic [2:0] sel;
   logic divSrc;
   logic lowSpeed;
   logic lowClk;
   logic halfTick;
   logic reservedSel;
   modport engine (output sel, output divSrc, output lowSpeed, output lowClk, input halfTick, input reservedSel);
   modport divider (input sel, input divSrc, input lowSpeed, input lowClk, output halfTick, output reservedSel);
endinterface

// ==== serial_clk_div.sv ====
// Half-period tick generator for the internal serial clock
`timescale 1ns/10ps
`include "sync_serial_defs.svh"
module serial_clk_div (
   input wire logic core_clk,
   input wire logic rst,
   clk_div_if.divider div
);
   import sync_serial_pkg::*;

   div_state_t s;
   div_state_t n;
   logic fsMode;
   logic advance;
   logic [11:0] half;
   logic [3:0] exponent;

   // Slow code follows the low clock when the source bit or low-speed mode says so
   assign fsMode = (div.sel == `SEL_SLOW) && (div.divSrc || div.lowSpeed);
   assign div.reservedSel = div.lowSpeed && (div.sel != `SEL_SLOW) && (div.sel != `SEL_EXT);
   assign exponent = (div.sel == `SEL_SLOW) ? `FC_EXP_SLOW : 4'(`FC_EXP_BASE - {1'b0, div.sel});
   assign half = fsMode ? `FS_HALF_EDGES : 12'(12'h001 << (exponent - 4'h1));
   assign advance = fsMode ? (div.lowClk && !s.lowPrev) : 1'b1;
   assign div.halfTick = s.tick;

   always_comb begin
      n = s;
      n.tick = 1'b0;
      n.lowPrev = div.lowClk;
      if (div.reservedSel || div.sel == `SEL_EXT) begin
         n.cnt = 12'h000;
      end else if (advance) begin
         if (s.cnt >= half - 12'h001) begin
            n.cnt = 12'h000;
            n.tick = 1'b1;
         end else begin
            n.cnt = s.cnt + 12'h001;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   logic [11:0] gap;
   logic seenTick;
   logic [2:0] selPrev;
   logic fsPrev;
   // A change of source with the same code must also restart the spacing check
   always_ff @(posedge core_clk) begin
      if (rst) begin
         gap <= 12'h000;
         seenTick <= 1'b0;
         selPrev <= 3'h0;
         fsPrev <= 1'b0;
      end else begin
         gap <= s.tick ? 12'h000 : gap + 12'h001;
         selPrev <= div.sel;
         fsPrev <= fsMode;
         seenTick <= (div.sel != selPrev || fsMode != fsPrev) ? 1'b0 : (seenTick || s.tick);
      end
   end

   AST_FC_RATE: assert property (@(posedge core_clk) disable iff (rst)
      s.tick && seenTick && !fsMode && !div.reservedSel && div.sel == selPrev |-> gap == half - 12'h001)
      else $error("fast divider tick spacing wrong");
   AST_FS_EDGE: assert property (@(posedge core_clk) disable iff (rst)
      s.tick && $past(fsMode) |-> $past(div.lowClk) && !$past(div.lowClk, 2))
      else $error("slow tick not tied to a low clock edge");
   AST_SLOW_RESERVED: assert property (@(posedge core_clk) disable iff (rst)
      div.reservedSel [*2] |-> !s.tick)
      else $error("reserved code produced a clock");
endmodule

// ==== serial_partner.sv ====
// Behavioural external serial device on the clock and data pins
`timescale 1ns/10ps
module serial_partner (
   input wire logic sckPin,
   input wire logic dataFromPort,
   input wire logic order,
   input wire logic clear,
   input wire logic [7:0] txByte,
   output logic dataToPort,
   output logic extClk,
   output logic [7:0] rxByte
);
   logic [7:0] txShift = 8'h00;
   logic [7:0] rxShift = 8'h00;
   logic hold = 1'b0;
   int fallCnt = 0;
   int riseCnt = 0;
   initial begin
      dataToPort = 1'b1;
      extClk = 1'b1;
      rxByte = 8'h00;
   end
   // Clock runs only inside a frame and stands high between frames
   task automatic send_clock(input int halfNs);
      repeat (8) begin
         extClk = 1'b0;
         #halfNs;
         extClk = 1'b1;
         #halfNs;
      end
   endtask
   always @(posedge clear) begin
      fallCnt = 0;
      riseCnt = 0;
   end
   always @(negedge sckPin) begin
      hold = 1'b0;
      if (fallCnt == 0)
         txShift = txByte;
      dataToPort = order ? txShift[0] : txShift[7];
      txShift = order ? txShift >> 1 : txShift << 1;
      fallCnt = (fallCnt + 1) % 8;
   end
   always @(posedge sckPin) begin
      rxShift = order ? {dataFromPort, rxShift[7:1]} : {rxShift[6:0], dataFromPort};
      riseCnt = (riseCnt + 1) % 8;
      if (riseCnt == 0) begin
         rxByte = rxShift;
         hold = 1'b1;
         // Last bit is not held forever, so a late sample shows up
         fork
            begin
               #600;
               if (hold)
                  dataToPort = ~dataToPort;
            end
         join_none
      end
   end
endmodule

// ==== sync_serial_clock_and_shift.sv ====
// Clock selection and bit shifter of the synchronous serial port with its APB registers
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`include "sync_serial_defs.svh"
// Functional notes
// - Any selection except 111 drives the pin; all but the low-speed reserved codes make the clock internally.
// - Internal clock pin stays high before and after each transfer.
// - Internal clock stops while transmit byte unwritten in transmit modes or received byte unread in receive modes.
// - After buffer access the clock resumes within one serial clock period.
// - Codes 001 to 110 divide the fast clock by 2^8 down to 2^3.
// - Code 000 divides fast clock by 2^12, or slow clock by 2^4.
// - In low-speed modes only codes 000 and 111 work, 000 as slow clock over 2^4.
// - Code 111 takes the clock the partner drives onto the pin.
// - Transmit bits change on the falling edge of the clock pin.
// - Receive bits are sampled on the rising edge of the clock pin.
// - One bit-order setting serves both transmit and receive.
// - Order zero moves bit 7 first, order one moves bit 0 first.
// - Busy flag is one during a transfer and zero after it ends.
// - Transmit waits at high clock after last bit until buffer written.
// - Receive waits at high clock after eight bits until buffer read.
module sync_serial_clock_and_shift #(
   parameter int ADDR_W = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serialClockIn,
   output logic serialClockOut,
   output logic serialClockOe,
   output logic serialOut,
   input wire logic serialIn,
   input wire logic lowFreqClock
);
   import sync_serial_pkg::*;

   initial begin
      if (ADDR_W < 5) begin
         $error("ADDR_W too small for the register map");
      end
   end

   function automatic logic hitReg(input logic [ADDR_W-1:0] addr, input logic [4:0] off);
      hitReg = (addr[4:0] == off) && (addr[ADDR_W-1:5] == '0);
   endfunction

   function automatic logic [7:0] shiftOn(input logic [7:0] v, input logic lsbFirst, input logic fill);
      shiftOn = lsbFirst ? {fill, v[7:1]} : {v[6:0], fill};
   endfunction

   port_state_t s;
   port_state_t n;
   clk_div_if divBus ();

   logic extClk;
   logic txMode;
   logic rxMode;
   logic ready;
   logic fallEv;
   logic riseEv;
   logic [7:0] rxNext;
   logic [7:0] loadWord;

   serial_clk_div clkDiv (
      .core_clk(core_clk),
      .rst(rst),
      .div(divBus.divider)
   );

   assign divBus.sel = s.clkSel;
   assign divBus.divSrc = s.divSrc;
   assign divBus.lowSpeed = s.lowSpeed;
   assign divBus.lowClk = lowFreqClock;

   assign extClk = (s.clkSel == `SEL_EXT);
   assign txMode = (s.mode == `MODE_TX) || (s.mode == `MODE_TXRX);
   assign rxMode = (s.mode == `MODE_RX) || (s.mode == `MODE_TXRX);
   // Next byte may start only once software has serviced each buffer the current mode uses
   assign ready = s.start && (!txMode || !s.txEmpty) && (!rxMode || !s.rxFull);
   // Only the second and third synchroniser stages feed the edge detector
   always_comb begin
      if (extClk) begin
         fallEv = s.sync3 && !s.sync2 && !s.lowPhase && (s.state == ST_SHIFT || s.start);
         riseEv = !s.sync3 && s.sync2 && s.lowPhase;
      end else begin
         fallEv = divBus.halfTick && !s.lowPhase && ((s.bitCnt != 4'h0) || ready);
         riseEv = divBus.halfTick && s.lowPhase;
      end
   end
   assign rxNext = shiftOn(s.rxShift, s.order, serialIn);
   // Underrun in receive-only or error case sends ones so the line stays high
   assign loadWord = (txMode && !s.txEmpty) ? s.txBuf : 8'hff;

   always_comb begin
      logic forceStop;
      forceStop = 1'b0;
      n = s;
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      n.sync1 = serialClockIn;
      n.sync2 = s.sync1;
      n.sync3 = s.sync2;
      n.sckOe = !extClk;

      // Register access, answered one cycle into the access phase
      if (psel && penable && !s.pready) begin
         n.pready = 1'b1;
         n.prdata = 32'h0000_0000;
         if (hitReg(paddr, `OFF_CTRL)) begin
            if (pwrite) begin
               n.start = pwdata[`CTRL_START];
               n.mode = pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
               n.order = pwdata[`CTRL_ORDER];
               n.clkSel = pwdata[`CTRL_SEL_HI:`CTRL_SEL_LO];
               forceStop = pwdata[`CTRL_FORCE_STOP];
            end else begin
               n.prdata[`CTRL_START] = s.start;
               n.prdata[`CTRL_MODE_HI:`CTRL_MODE_LO] = s.mode;
               n.prdata[`CTRL_ORDER] = s.order;
               n.prdata[`CTRL_SEL_HI:`CTRL_SEL_LO] = s.clkSel;
            end
         end else if (hitReg(paddr, `OFF_STATUS)) begin
            if (pwrite) begin
               n.txErr = s.txErr && pwdata[`STAT_TX_ERR];
               n.rxErr = s.rxErr && pwdata[`STAT_RX_ERR];
            end else begin
               n.prdata[`STAT_BUSY] = s.busy;
               n.prdata[`STAT_PARTIAL] = (s.state == ST_SHIFT) && (s.bitCnt != 4'h0 || s.lowPhase);
               n.prdata[`STAT_TX_EMPTY] = s.txEmpty;
               n.prdata[`STAT_RX_FULL] = s.rxFull;
               n.prdata[`STAT_TX_ERR] = s.txErr;
               n.prdata[`STAT_RX_ERR] = s.rxErr;
            end
         end else if (hitReg(paddr, `OFF_TXBUF)) begin
            // A write into a full buffer is dropped
            if (pwrite && s.txEmpty) begin
               n.txBuf = pwdata[7:0];
               n.txEmpty = 1'b0;
            end
         end else if (hitReg(paddr, `OFF_RXBUF)) begin
            if (!pwrite) begin
               n.prdata[7:0] = s.rxBuf;
               n.rxFull = 1'b0;
            end
         end else if (hitReg(paddr, `OFF_CLKCFG)) begin
            if (pwrite) begin
               n.divSrc = pwdata[`CFG_DIV_SRC];
               n.lowSpeed = pwdata[`CFG_LOW_SPEED];
            end else begin
               n.prdata[`CFG_DIV_SRC] = s.divSrc;
               n.prdata[`CFG_LOW_SPEED] = s.lowSpeed;
               n.prdata[`CFG_RESERVED_SEL] = divBus.reservedSel;
            end
         end else begin
            n.pslverr = 1'b1;
         end
      end

      // Hardware events come after register access so a set beats a clear, except a force stop, which is applied last
      if (fallEv) begin
         n.lowPhase = 1'b1;
         n.state = ST_SHIFT;
         n.busy = 1'b1;
         if (!extClk) begin
            n.sckOut = 1'b0;
         end
         if (s.bitCnt == 4'h0) begin
            n.serOut = s.order ? loadWord[0] : loadWord[7];
            n.txShift = shiftOn(loadWord, s.order, 1'b1);
            if (txMode) begin
               n.txEmpty = 1'b1;
               if (s.txEmpty) begin
                  n.txErr = 1'b1;
               end
            end
         end else begin
            n.serOut = s.order ? s.txShift[0] : s.txShift[7];
            n.txShift = shiftOn(s.txShift, s.order, 1'b1);
         end
      end

      if (riseEv) begin
         n.lowPhase = 1'b0;
         n.rxShift = rxNext;
         n.bitCnt = s.bitCnt + 4'h1;
         if (!extClk) begin
            n.sckOut = 1'b1;
         end
         if (s.bitCnt == 4'h7) begin
            n.bitCnt = 4'h0;
            if (rxMode) begin
               if (s.rxFull && !(n.rxFull == 1'b0)) begin
                  n.rxErr = 1'b1;
               end else begin
                  n.rxBuf = rxNext;
                  n.rxFull = 1'b1;
               end
            end
            if (!s.start) begin
               n.state = ST_IDLE;
               n.busy = 1'b0;
               n.serOut = 1'b1;
            end
         end
      end

      // Between bytes with start cleared the engine also goes idle
      if (s.state == ST_SHIFT && s.bitCnt == 4'h0 && !s.lowPhase && !s.start && !fallEv) begin
         n.state = ST_IDLE;
         n.busy = 1'b0;
         n.serOut = 1'b1;
      end

      if (extClk) begin
         n.sckOut = 1'b1;
      end

      if (forceStop) begin
         n.start = 1'b0;
         n.state = ST_IDLE;
         n.busy = 1'b0;
         n.bitCnt = 4'h0;
         n.lowPhase = 1'b0;
         n.txBuf = 8'h00;
         n.rxBuf = 8'h00;
         n.txEmpty = 1'b1;
         n.rxFull = 1'b0;
         n.txErr = 1'b0;
         n.rxErr = 1'b0;
         n.serOut = 1'b1;
         n.sckOut = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s <= '0;
         s.txEmpty <= 1'b1;
         s.sckOut <= 1'b1;
         s.sckOe <= 1'b1;
         s.serOut <= 1'b1;
         s.sync1 <= 1'b1;
         s.sync2 <= 1'b1;
         s.sync3 <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign serialClockOut = s.sckOut;
   assign serialClockOe = s.sckOe;
   assign serialOut = s.serOut;

   localparam int RESUME_MAX = 258;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence sStalled;
      !extClk && s.bitCnt == 4'h0 && !s.lowPhase && !ready;
   endsequence

   sequence sArmed;
      !extClk && s.clkSel != `SEL_SLOW && !divBus.reservedSel && s.bitCnt == 4'h0 && !s.lowPhase && ready;
   endsequence

   sequence sTxStarved;
      !extClk && s.state == ST_SHIFT && s.bitCnt == 4'h0 && !s.lowPhase && txMode && s.txEmpty;
   endsequence

   sequence sRxUnread;
      !extClk && s.state == ST_SHIFT && s.bitCnt == 4'h0 && !s.lowPhase && rxMode && s.rxFull;
   endsequence

   AST_INT_DRIVE: assert property ((s.clkSel != `SEL_EXT) [*2] |-> s.sckOe)
      else $error("internal clock not driven on pin");
   AST_EXT_RELEASE: assert property ((s.clkSel == `SEL_EXT) [*2] |-> !s.sckOe)
      else $error("pin driven while external clock selected");
   AST_IDLE_HIGH: assert property ((!extClk && s.state == ST_IDLE) [*2] |-> s.sckOut)
      else $error("clock pin not high outside transfer");
   AST_AUTO_WAIT: assert property (sStalled |=> s.sckOut && !s.lowPhase)
      else $error("clock ran while waiting for buffer service");
   AST_RESUME: assert property (sArmed |-> ##[1:RESUME_MAX] (!s.sckOut || !ready))
      else $error("clock did not resume within one period");
   AST_TX_WAIT: assert property (sTxStarved |=> s.sckOut && s.bitCnt == 4'h0)
      else $error("transmit did not wait for new byte");
   AST_RX_WAIT: assert property (sRxUnread |=> s.sckOut && s.bitCnt == 4'h0)
      else $error("receive did not wait for buffer read");
   AST_FIRST_BIT: assert property (fallEv && s.bitCnt == 4'h0 && txMode && !s.txEmpty |=>
      s.serOut == ($past(s.order) ? $past(s.txBuf[0]) : $past(s.txBuf[7])))
      else $error("first transmit bit wrong");
   AST_RX_LAST: assert property (riseEv && s.bitCnt == 4'h7 && rxMode && !s.rxFull |=>
      s.rxFull && s.rxBuf[$past(s.order) ? 3'h7 : 3'h0] == $past(serialIn))
      else $error("last received bit misplaced");
   AST_BUSY_LOW_PHASE: assert property (s.lowPhase |-> s.busy && s.state == ST_SHIFT)
      else $error("busy flag low during shifting");
   AST_EXT_SYNC: assert property (extClk && riseEv |-> $past(serialClockIn, 2) && !$past(serialClockIn, 3))
      else $error("external edge not from synchronised pin");
endmodule

// ==== sync_serial_clock_and_shift_bench.sv ====
// Self-checking bench for the serial clock and shift block
`timescale 1ns/10ps
`include "sync_serial_defs.svh"
module sync_serial_clock_and_shift_bench;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, serialClockOut, serialClockOe, serialOut, serialIn, extClk;
   logic lowFreqClock = 1'b0;
   logic pOrder = 1'b0, pClear = 1'b0, prevSck = 1'b1;
   logic [7:0] pTx = 8'h00;
   logic [7:0] pRx;
   wire logic sckPin;
   int failCount = 0, checked = 0, cyc = 0, fallAt = 0, halfLen = 0, rises = 0, falls = 0, lfDiv = 0;
   assign sckPin = serialClockOe ? serialClockOut : extClk;
   sync_serial_clock_and_shift u_sync_serial_clock_and_shift (.core_clk(core_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serialClockIn(sckPin), .serialClockOut(serialClockOut), .serialClockOe(serialClockOe),
      .serialOut(serialOut), .serialIn(serialIn), .lowFreqClock(lowFreqClock));
   serial_partner u_serial_partner (.sckPin(sckPin), .dataFromPort(serialOut), .order(pOrder), .clear(pClear),
      .txByte(pTx), .dataToPort(serialIn), .extClk(extClk), .rxByte(pRx));
   initial forever #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      prevSck <= sckPin;
      lfDiv <= (lfDiv == 4) ? 0 : lfDiv + 1;
      if (lfDiv == 4)
         lowFreqClock <= ~lowFreqClock;
      if (prevSck && !sckPin) begin
         falls <= falls + 1;
         fallAt <= cyc;
      end
      if (!prevSck && sckPin) begin
         rises <= rises + 1;
         halfLen <= cyc - fallAt;
      end
   end
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
      checked++;
      if (seen !== exp) begin
         failCount++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      // No fixed wait count; only the watchdog ends a hung access
      while (pready !== 1'b1) begin
         @(posedge core_clk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      check(name, exp, q);
   endtask
   function automatic logic [31:0] ctl(input logic [1:0] m, input logic o, input logic [2:0] s);
      return {24'h0, 1'b1, 1'b0, m, o, s};
   endfunction
   task automatic wait_rises(input int target, input int lim);
      for (int k = 0; k < lim && rises < target; k++)
         @(posedge core_clk);
   endtask
   task automatic fresh(input logic [2:0] cfg);
      wr(`OFF_CTRL, 32'h1 << `CTRL_FORCE_STOP);
      wr(`OFF_CLKCFG, {29'h0, cfg});
      pClear <= 1'b1;
      @(posedge core_clk);
      pClear <= 1'b0;
   endtask
   task automatic measure(input logic [2:0] code, input logic [2:0] cfg, input int half);
      fresh(cfg);
      wr(`OFF_TXBUF, 32'h55);
      wr(`OFF_CTRL, ctl(`MODE_TX, 1'b0, code));
      wait_rises(rises + 1, 3 * half + 60);
      check("half period", half, halfLen);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checked, failCount);
      if (failCount == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge core_clk);
      failCount++;
      close_out();
   end
   initial begin
      logic [31:0] q;
      logic e;
      int f;
      int r0;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      rdchk("ctrl reset", `OFF_CTRL, 32'h0);
      rdchk("status reset", `OFF_STATUS, 32'h20);
      rdchk("clkcfg reset", `OFF_CLKCFG, 32'h0);
      apb(1'b0, 8'h14, 32'h0, q, e);
      check("unmapped err", 1, e);
      check("pin idle high", 1, sckPin);
      check("pin driven", 1, serialClockOe);
      $display("test reset done");
      for (int c = 1; c < 7; c++)
         measure(c[2:0], {2'b0, c[0]}, 1 << (8 - c));
      measure(3'h0, 3'h0, 2048);
      measure(3'h0, 3'h1, 80);
      measure(3'h0, 3'h2, 80);
      fresh(3'h2);
      wr(`OFF_TXBUF, 32'h55);
      wr(`OFF_CTRL, ctl(`MODE_TX, 1'b0, 3'h1));
      f = falls;
      repeat (400) @(posedge core_clk);
      check("reserved no clock", f, falls);
      rdchk("reserved flag", `OFF_CLKCFG, 32'h6);
      $display("test clock rates done");
      fresh(3'h0);
      wr(`OFF_TXBUF, 32'ha5);
      r0 = rises;
      wr(`OFF_CTRL, ctl(`MODE_TX, 1'b0, 3'h6));
      wait_rises(r0 + 1, 40);
      apb(1'b0, `OFF_STATUS, 32'h0, q, e);
      check("busy", 1, q[`STAT_BUSY]);
      wait_rises(r0 + 8, 200);
      check("tx msb byte", 8'ha5, pRx);
      f = falls;
      repeat (40) @(posedge core_clk);
      check("tx auto wait", f, falls);
      check("wait level", 1, sckPin);
      wr(`OFF_TXBUF, 32'h3c);
      repeat (10) @(posedge core_clk);
      check("tx resume", 1, falls > f);
      wait_rises(r0 + 16, 200);
      check("tx second byte", 8'h3c, pRx);
      wr(`OFF_CTRL, 32'h06);
      for (int i = 0; i < 30; i++) begin
         apb(1'b0, `OFF_STATUS, 32'h0, q, e);
         if (q[`STAT_BUSY] === 1'b0)
            break;
      end
      check("busy clear", 0, q[`STAT_BUSY]);
      check("data idle", 1, serialOut);
      check("pin high after", 1, sckPin);
      $display("test transmit wait done");
      fresh(3'h0);
      pOrder <= 1'b1;
      pTx <= 8'h96;
      r0 = rises;
      wr(`OFF_CTRL, ctl(`MODE_RX, 1'b1, 3'h6));
      wait_rises(r0 + 8, 200);
      f = falls;
      repeat (40) @(posedge core_clk);
      check("rx auto wait", f, falls);
      rdchk("rx lsb byte", `OFF_RXBUF, 32'h96);
      repeat (10) @(posedge core_clk);
      check("rx resume", 1, falls > f);
      $display("test receive wait done");
      fresh(3'h0);
      pTx <= 8'h1e;
      wr(`OFF_TXBUF, 32'hb4);
      wr(`OFF_CTRL, ctl(`MODE_TXRX, 1'b1, `SEL_EXT));
      repeat (2) @(posedge core_clk);
      check("pin released", 0, serialClockOe);
      #30;
      u_serial_partner.send_clock(800);
      repeat (10) @(posedge core_clk);
      check("ext tx lsb", 8'hb4, pRx);
      rdchk("ext rx lsb", `OFF_RXBUF, 32'h1e);
      rdchk("ext status", `OFF_STATUS, 32'ha0);
      $display("test external clock done");
      close_out();
   end
endmodule

// ==== sync_serial_defs.svh ====
// Register offsets, field positions, reset values and clock counts of the serial port
`ifndef SYNC_SERIAL_DEFS_SVH
`define SYNC_SERIAL_DEFS_SVH

`define OFF_CTRL 5'h00
`define OFF_STATUS 5'h04
`define OFF_TXBUF 5'h08
`define OFF_RXBUF 5'h0c
`define OFF_CLKCFG 5'h10

`define CTRL_START 7
`define CTRL_FORCE_STOP 6
`define CTRL_MODE_HI 5
`define CTRL_MODE_LO 4
`define CTRL_ORDER 3
`define CTRL_SEL_HI 2
`define CTRL_SEL_LO 0

`define STAT_BUSY 7
`define STAT_PARTIAL 6
`define STAT_TX_EMPTY 5
`define STAT_RX_FULL 4
`define STAT_TX_ERR 3
`define STAT_RX_ERR 2

`define CFG_DIV_SRC 0
`define CFG_LOW_SPEED 1
`define CFG_RESERVED_SEL 2

`define CTRL_RESET 8'h00
`define STATUS_RESET 8'h20

`define SEL_EXT 3'h7
`define SEL_SLOW 3'h0
`define MODE_TX 2'h0
`define MODE_RX 2'h1
`define MODE_TXRX 2'h2

`define CORE_CLK_NS 100
`define FC_EXP_BASE 4'h9
`define FC_EXP_SLOW 4'hc
`define FS_HALF_EDGES 12'h008

`endif

// ==== sync_serial_pkg.sv ====
// Types shared by the serial port modules
package sync_serial_pkg;
   typedef enum logic {ST_IDLE, ST_SHIFT} shift_state_t;

   typedef struct packed {
      logic [11:0] cnt;
      logic lowPrev;
      logic tick;
   } div_state_t;

   typedef struct packed {
      logic start;
      logic [1:0] mode;
      logic order;
      logic [2:0] clkSel;
      logic divSrc;
      logic lowSpeed;
      shift_state_t state;
      logic [3:0] bitCnt;
      logic lowPhase;
      logic [7:0] txShift;
      logic [7:0] rxShift;
      logic [7:0] txBuf;
      logic [7:0] rxBuf;
      logic txEmpty;
      logic rxFull;
      logic txErr;
      logic rxErr;
      logic busy;
      logic sckOut;
      logic sckOe;
      logic serOut;
      logic sync1;
      logic sync2;
      logic sync3;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } port_state_t;
endpackage
